// ==== rtl/mem_access_defs.vh ====
// Register offsets, field positions, reset values and sizes of the indirect
// memory access port.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef MEM_ACCESS_DEFS_VH
`define MEM_ACCESS_DEFS_VH

// ****************************************************************
// Register offsets (I2C register address space)
// ****************************************************************
`define OFS_LIVE_CHECKSUM 8'h8a
`define OFS_MEM_ADDR_HIGH 8'h8b
`define OFS_MEM_ADDR_LOW 8'h8c
`define OFS_NONVOLATILE_READ_DATA 8'h8d
`define OFS_SRAM_READ_WRITE_DATA 8'h8e
`define OFS_ROM_READ_DATA 8'h8f

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ADDR_HIGH_MSB 3
`define ADDR_HIGH_RST 4'h0
`define ADDR_LOW_RST 8'h00
`define CHECKSUM_RST 8'h00
`define DATA_RST 8'h00
`define CRC_POLY 8'h07

// ****************************************************************
// Memory sizes
// ****************************************************************
`define NV_AW 9
`define NV_DEPTH 512
`define ROM_AW 12
`define ROM_DEPTH 4096

`endif

// ==== rtl/word_buffer2.v ====
// Two-entry valid/ready buffer for read data words.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
module word_buffer2 (
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	// Fill side
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [7:0] i_in_data,
	// Drain side
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [7:0] o_out_data
);
	reg [7:0] mem_r [0:1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] count_r;
	wire push;
	wire pop;

	assign o_in_ready = (count_r != 2'd2);
	assign o_out_valid = (count_r != 2'd0);
	assign o_out_data = mem_r[rd_ptr_r];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'd0;
			mem_r[0] <= 8'h00;
			mem_r[1] <= 8'h00;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= i_in_data;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			if (push && !pop)
				count_r <= count_r + 2'd1;
			else if (pop && !push)
				count_r <= count_r - 2'd1;
		end
	end
endmodule // word_buffer2

// ==== rtl/sram_array.v ====
// Byte-wide synchronous single-port SRAM, one cycle read latency.
// Assumes one clock; contents are undefined after power-up.
`timescale 1ns/10ps
module sram_array (
	// Clock
	input wire i_clk,
	// Access port
	input wire i_we,
	input wire [8:0] i_addr,
	input wire [7:0] i_wdata,
	output reg [7:0] o_rdata
);
	reg [7:0] mem [0:511];

	always @(posedge i_clk) begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		o_rdata <= mem[i_addr];
	end
endmodule // sram_array

// ==== rtl/mem_access_port.v ====
// Indirect memory access port behind the I2C register space.
// Assumes an I2C slave front end that presents one byte access at a time,
// marks the end of each transaction with a pulse, and owns the register
// address pointer (it obeys o_addr_lock). Nonvolatile and ROM arrays are
// external and answer in the same cycle as their read strobe.
//
// Function
// - A read-only 8-bit live checksum is updated during nonvolatile reads and cleared on reset.
// - Start address bits 11..8 live in bits 3..0 of the high address register, upper bits zero.
// - Start address bits 7..0 live in the low address register, reset to zero.
// - Nonvolatile and SRAM use a 9-bit address, ROM uses the full 12-bit address.
// - The first nonvolatile data read of a transaction returns the byte at the start address.
// - Each further nonvolatile read in the transaction increments the address.
// - After the first nonvolatile data access the register address stays locked there.
// - The nonvolatile data access lock ends when the transaction ends.
// - The first SRAM data access reads or writes the byte at the start address.
// - Each further SRAM access in the transaction increments the address first.
// - After the first SRAM data access the register address stays locked there.
// - The SRAM data lock and burst end when the transaction ends.
// - ROM data reads start at the start address, increment before each further read, and lock the address.
`timescale 1ns/10ps
`include "mem_access_defs.vh"
module mem_access_port (
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	// Register access from the I2C slave
	input wire i_acc_valid,
	output wire o_acc_ready,
	input wire i_acc_write,
	input wire [7:0] i_acc_addr,
	input wire [7:0] i_acc_wdata,
	input wire i_txn_end,
	// Read answer to the I2C slave
	output wire o_rd_valid,
	input wire i_rd_ready,
	output wire [7:0] o_rd_data,
	// Register address pointer control
	output wire o_addr_lock,
	// Nonvolatile array read port
	output reg [8:0] o_nv_addr,
	output reg o_nv_rd,
	input wire [7:0] i_nv_rdata,
	// ROM read port
	output reg [11:0] o_rom_addr,
	output reg o_rom_rd,
	input wire [7:0] i_rom_rdata
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_PUSH = 3'b100;

	localparam SRC_REG = 2'd0;
	localparam SRC_NV = 2'd1;
	localparam SRC_RAM = 2'd2;
	localparam SRC_ROM = 2'd3;

	// CRC-8 step over one byte
	function [7:0] crc8_byte;
		input [7:0] crc;
		input [7:0] data;
		reg [7:0] c;
		integer i;
		begin
			c = crc ^ data;
			for (i = 0; i < 8; i = i + 1)
				c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
			crc8_byte = c;
		end
	endfunction

	// True for the three data registers that lock the register address
	function is_mem_data;
		input [7:0] addr;
		begin
			is_mem_data = (addr == `OFS_NONVOLATILE_READ_DATA) ||
				(addr == `OFS_SRAM_READ_WRITE_DATA) ||
				(addr == `OFS_ROM_READ_DATA);
		end
	endfunction

	// Where the answer byte of a read comes from
	function [1:0] read_source;
		input [7:0] addr;
		begin
			case (addr)
			`OFS_NONVOLATILE_READ_DATA: read_source = SRC_NV;
			`OFS_SRAM_READ_WRITE_DATA: read_source = SRC_RAM;
			`OFS_ROM_READ_DATA: read_source = SRC_ROM;
			default: read_source = SRC_REG;
			endcase
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg [3:0] addr_high_r;
	reg [7:0] addr_low_r;
	reg [7:0] checksum_r;
	reg [11:0] ptr_r;
	reg [11:0] ptr_nxt;
	reg burst_r;
	reg locked_r;
	reg [2:0] state_r;
	reg [1:0] src_r;
	reg [7:0] reg_rdata_r;
	reg [7:0] nv_data_r;
	reg [7:0] ram_data_r;
	reg ram_we;
	reg [8:0] ram_addr;
	wire [7:0] ram_rdata;
	reg [7:0] push_data;
	wire buf_in_ready;
	wire is_data;
	wire take;
	wire rd_take;
	wire [1:0] rd_src;
	wire nv_rd_take;
	wire rom_rd_take;
	wire wait_cycle;
	wire push_valid;
	reg [2:0] state_nxt;

	assign is_data = is_mem_data(i_acc_addr);
	assign o_acc_ready = (state_r == ST_IDLE) && !i_txn_end;
	assign take = i_acc_valid && o_acc_ready;
	assign o_addr_lock = locked_r;

	// ****************************************************************
	// Pointer: reload on first data access, increment on later ones
	// ****************************************************************
	always @* begin
		if (!burst_r)
			ptr_nxt = {addr_high_r, addr_low_r};
		else
			ptr_nxt = ptr_r + 12'd1;
	end

	always @* begin
		ram_we = 1'b0;
		ram_addr = ptr_r[8:0];
		if (take && (i_acc_addr == `OFS_SRAM_READ_WRITE_DATA)) begin
			ram_addr = ptr_nxt[8:0];
			ram_we = i_acc_write;
		end
	end

	sram_array u_sram (
		.i_clk(i_clk),
		.i_we(ram_we),
		.i_addr(ram_addr),
		.i_wdata(i_acc_wdata),
		.o_rdata(ram_rdata)
	);

	// ****************************************************************
	// Answer sequencer
	// ****************************************************************
	// A read is taken in IDLE, the array answers during WAIT, and the byte
	// enters the buffer from PUSH. A full buffer holds the sequencer in PUSH,
	// which keeps o_acc_ready low so no answer is lost.
	assign rd_take = take && !i_acc_write;
	assign rd_src = read_source(i_acc_addr);
	assign nv_rd_take = rd_take && (rd_src == SRC_NV);
	assign rom_rd_take = rd_take && (rd_src == SRC_ROM);
	assign wait_cycle = (state_r == ST_WAIT);
	assign push_valid = (state_r == ST_PUSH);

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (rd_take)
				state_nxt = ST_WAIT;
		end
		ST_WAIT: begin
			state_nxt = ST_PUSH;
		end
		ST_PUSH: begin
			if (buf_in_ready)
				state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= ST_IDLE;
			src_r <= SRC_REG;
		end else begin
			state_r <= state_nxt;
			if (rd_take)
				src_r <= rd_src;
		end
	end

	// ****************************************************************
	// Start address registers
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_srst)
			addr_high_r <= `ADDR_HIGH_RST;
		else if (take && i_acc_write && (i_acc_addr == `OFS_MEM_ADDR_HIGH))
			addr_high_r <= i_acc_wdata[`ADDR_HIGH_MSB:0];
	end

	always @(posedge i_clk) begin
		if (i_srst)
			addr_low_r <= `ADDR_LOW_RST;
		else if (take && i_acc_write && (i_acc_addr == `OFS_MEM_ADDR_LOW))
			addr_low_r <= i_acc_wdata;
	end

	// ****************************************************************
	// Burst pointer and register address lock
	// ****************************************************************
	// A take never meets i_txn_end, since o_acc_ready is low while it stands
	always @(posedge i_clk) begin
		if (i_srst)
			ptr_r <= 12'h000;
		else if (take && is_data)
			ptr_r <= ptr_nxt;
	end

	always @(posedge i_clk) begin
		if (i_srst)
			burst_r <= 1'b0;
		else if (i_txn_end)
			burst_r <= 1'b0;
		else if (take && is_data)
			burst_r <= 1'b1;
	end

	always @(posedge i_clk) begin
		if (i_srst)
			locked_r <= 1'b0;
		else if (i_txn_end)
			locked_r <= 1'b0;
		else if (take && is_data)
			locked_r <= 1'b1;
	end

	// ****************************************************************
	// Register read byte
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_srst) begin
			reg_rdata_r <= `DATA_RST;
		end else if (rd_take) begin
			case (i_acc_addr)
			`OFS_LIVE_CHECKSUM: reg_rdata_r <= checksum_r;
			`OFS_MEM_ADDR_HIGH: reg_rdata_r <= {4'h0, addr_high_r};
			`OFS_MEM_ADDR_LOW: reg_rdata_r <= addr_low_r;
			default: reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Nonvolatile and ROM read strobes
	// ****************************************************************
	// Each strobe stands one cycle with its address; the array answers
	// while it stands, and the byte is taken at the end of WAIT
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_nv_addr <= 9'h000;
			o_nv_rd <= 1'b0;
		end else begin
			o_nv_rd <= nv_rd_take;
			if (nv_rd_take)
				o_nv_addr <= ptr_nxt[8:0];
		end
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_rom_addr <= 12'h000;
			o_rom_rd <= 1'b0;
		end else begin
			o_rom_rd <= rom_rd_take;
			if (rom_rd_take)
				o_rom_addr <= ptr_nxt;
		end
	end

	// ****************************************************************
	// Live checksum over every nonvolatile byte read
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_srst)
			checksum_r <= `CHECKSUM_RST;
		else if (wait_cycle && (src_r == SRC_NV))
			checksum_r <= crc8_byte(checksum_r, i_nv_rdata);
	end

	// ****************************************************************
	// Array answer capture
	// ****************************************************************
	// Array outputs are only valid for one cycle, so hold them
	always @(posedge i_clk) begin
		if (i_srst)
			nv_data_r <= `DATA_RST;
		else if (wait_cycle && (src_r == SRC_NV))
			nv_data_r <= i_nv_rdata;
	end

	always @(posedge i_clk) begin
		if (i_srst)
			ram_data_r <= `DATA_RST;
		else if (wait_cycle && (src_r == SRC_ROM))
			ram_data_r <= i_rom_rdata;
		else if (wait_cycle)
			ram_data_r <= ram_rdata;
	end

	always @* begin
		case (src_r)
		SRC_NV: push_data = nv_data_r;
		SRC_RAM: push_data = ram_data_r;
		SRC_ROM: push_data = ram_data_r;
		default: push_data = reg_rdata_r;
		endcase
	end

	// ****************************************************************
	// Read data buffer
	// ****************************************************************
	word_buffer2 u_rd_buf (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_in_valid(push_valid),
		.o_in_ready(buf_in_ready),
		.i_in_data(push_data),
		.o_out_valid(o_rd_valid),
		.i_out_ready(i_rd_ready),
		.o_out_data(o_rd_data)
	);
endmodule // mem_access_port

// ==== sim/mem_access_port_assertions.sv ====
// Port timing checker for mem_access_port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mem_access_port_chk (
	input wire i_clk,
	input wire i_srst,
	input wire i_acc_valid,
	input wire o_acc_ready,
	input wire i_acc_write,
	input wire [7:0] i_acc_addr,
	input wire i_txn_end,
	input wire o_rd_valid,
	input wire i_rd_ready,
	input wire [7:0] o_rd_data,
	input wire o_addr_lock,
	input wire o_nv_rd,
	input wire o_rom_rd
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire take = i_acc_valid && o_acc_ready;
	wire rd_tk = take && !i_acc_write;
	a_nv_lock: assert property (rd_tk && i_acc_addr == 8'h8d |=> o_nv_rd && o_addr_lock)
		else $error("nv read not started");
	a_rom_lock: assert property (rd_tk && i_acc_addr == 8'h8f |=> o_rom_rd && o_addr_lock)
		else $error("rom read not started");
	a_sram_lock: assert property (take && i_acc_addr == 8'h8e |=> o_addr_lock)
		else $error("sram access not locked");
	a_lock_end: assert property (i_txn_end |=> !o_addr_lock)
		else $error("lock kept after end");
	a_end_refuse: assert property (i_txn_end |-> !o_acc_ready)
		else $error("ready during end");
	a_read_lat: assert property (rd_tk |-> ##[1:3] o_rd_valid)
		else $error("read answer late");
	a_busy_gap: assert property (rd_tk |=> !o_acc_ready [*2])
		else $error("read taken too soon");
	a_rd_hold: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
		else $error("answer dropped");
	a_nv_pulse: assert property (o_nv_rd |=> !o_nv_rd)
		else $error("nv strobe too long");
endmodule // mem_access_port_chk
bind mem_access_port mem_access_port_chk chk (
	.i_clk(i_clk),
	.i_srst(i_srst),
	.i_acc_valid(i_acc_valid),
	.o_acc_ready(o_acc_ready),
	.i_acc_write(i_acc_write),
	.i_acc_addr(i_acc_addr),
	.i_txn_end(i_txn_end),
	.o_rd_valid(o_rd_valid),
	.i_rd_ready(i_rd_ready),
	.o_rd_data(o_rd_data),
	.o_addr_lock(o_addr_lock),
	.o_nv_rd(o_nv_rd),
	.o_rom_rd(o_rom_rd)
);

// ==== sim/mem_far_model.sv ====
// Model of the nonvolatile and ROM arrays.
// Assumes one-cycle read strobes, answered while the strobe stands.
`timescale 1ns/10ps
module mem_far_model (
	input wire i_clk,
	input wire [8:0] i_nv_addr,
	input wire i_nv_rd,
	output reg [7:0] o_nv_rdata,
	input wire [11:0] i_rom_addr,
	input wire i_rom_rd,
	output reg [7:0] o_rom_rdata
);
	reg [7:0] noise_r = 8'h00;
	// Outside the strobe cycle the bytes wander, so a late or early sample fails
	always @(posedge i_clk) noise_r <= noise_r + 8'h35;
	always @* begin
		o_nv_rdata = i_nv_rd ? i_nv_addr[7:0] ^ {7'h00, i_nv_addr[8]} ^ 8'h5a : noise_r;
		o_rom_rdata = i_rom_rd ? i_rom_addr[7:0] + {4'h0, i_rom_addr[11:8]} + 8'h3c : ~noise_r;
	end
endmodule // mem_far_model

// ==== sim/tb.sv ====
// Self-checking bench for mem_access_port.
// Assumes the array model in mem_far_model.sv.
`timescale 1ns/10ps
module tb;
	reg i_clk = 0, i_srst = 1, i_acc_valid = 0, i_acc_write = 0, i_txn_end = 0, i_rd_ready = 0;
	reg [7:0] i_acc_addr = 0, i_acc_wdata = 0, ck = 0;
	reg [15:0] lf = 16'hf348;
	reg [11:0] st;
	reg [7:0] sr [0:2];
	integer n_errors = 0, n_compared = 0, i, k;
	wire o_acc_ready, o_rd_valid, o_addr_lock, o_nv_rd, o_rom_rd;
	wire [7:0] o_rd_data, i_nv_rdata, i_rom_rdata;
	wire [8:0] o_nv_addr;
	wire [11:0] o_rom_addr;
	always #20 i_clk = ~i_clk;
	mem_access_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_acc_valid(i_acc_valid),
		.o_acc_ready(o_acc_ready), .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
		.i_acc_wdata(i_acc_wdata), .i_txn_end(i_txn_end), .o_rd_valid(o_rd_valid),
		.i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data), .o_addr_lock(o_addr_lock),
		.o_nv_addr(o_nv_addr), .o_nv_rd(o_nv_rd), .i_nv_rdata(i_nv_rdata),
		.o_rom_addr(o_rom_addr), .o_rom_rd(o_rom_rd), .i_rom_rdata(i_rom_rdata));
	mem_far_model far (.i_clk(i_clk), .i_nv_addr(o_nv_addr), .i_nv_rd(o_nv_rd),
		.o_nv_rdata(i_nv_rdata), .i_rom_addr(o_rom_addr), .i_rom_rd(o_rom_rd),
		.o_rom_rdata(i_rom_rdata));
	// ****
	// Expectations
	// ****
	function [15:0] nx(input [15:0] v);
		nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function [7:0] nvb(input [8:0] a);
		nvb = a[7:0] ^ {7'h00, a[8]} ^ 8'h5a;
	endfunction
	function [7:0] romb(input [11:0] a);
		romb = a[7:0] + {4'h0, a[11:8]} + 8'h3c;
	endfunction
	function [7:0] crc(input [7:0] c, input [7:0] d);
		integer j;
		begin
			crc = c ^ d;
			for (j = 0; j < 8; j = j + 1) crc = crc[7] ? (crc << 1) ^ 8'h07 : crc << 1;
		end
	endfunction
	// ****
	// Bus tasks
	// ****
	task chk(input [39:0] nm, input [7:0] e, input [7:0] s);
		begin
			n_compared = n_compared + 1;
			if (s !== e) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED %s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task req(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge i_clk);
			#1 {i_acc_valid, i_acc_write, i_acc_addr, i_acc_wdata} = {1'b1, w, a, d};
			do @(negedge i_clk); while (!o_acc_ready);
			@(posedge i_clk);
			#1 i_acc_valid = 0;
		end
	endtask
	task get(input [7:0] e);
		begin
			repeat (9) if (o_rd_valid !== 1'b1) @(negedge i_clk);
			chk("valid", 8'h01, {7'h00, o_rd_valid});
			chk("data", e, o_rd_data);
			@(posedge i_clk);
			#1 i_rd_ready = 1;
			@(posedge i_clk);
			#1 i_rd_ready = 0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			req(0, a, 8'h00);
			get(e);
		end
	endtask
	task te;
		begin
			@(posedge i_clk);
			#1 i_txn_end = 1;
			@(posedge i_clk);
			#1 i_txn_end = 0;
		end
	endtask
	task finish_test;
		begin
			$display("errors %0d compared %0d", n_errors, n_compared);
			if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		n_errors = n_errors + 1;
		finish_test;
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (2) @(posedge i_clk);
		#1 i_srst = 0;
		rd(8'h8a, 8'h00);
		rd(8'h8b, 8'h00);
		rd(8'h8c, 8'h00);
		rd(8'h80, 8'h00);
		req(1, 8'h8b, 8'hff);
		rd(8'h8b, 8'h0f);
		for (k = 0; k < 4; k = k + 1) begin
			lf = nx(lf);
			st = k ? lf[11:0] : 12'h1ff;
			req(1, 8'h8b, {4'h0, st[11:8]});
			req(1, 8'h8c, st[7:0]);
			te;
			for (i = 0; i < 3; i = i + 1) begin
				rd(8'h8d, nvb(st[8:0] + i));
				ck = crc(ck, nvb(st[8:0] + i));
			end
			te;
			for (i = 0; i < 2; i = i + 1) rd(8'h8f, romb(st + i));
			te;
			for (i = 0; i < 3; i = i + 1) begin
				lf = nx(lf);
				sr[i] = lf[7:0];
				req(1, 8'h8e, sr[i]);
			end
			te;
			for (i = 0; i < 3; i = i + 1) rd(8'h8e, sr[i]);
			te;
		end
		rd(8'h8a, ck);
		// Two answers fill the buffer; the third read stalls and blocks requests
		req(0, 8'h8c, 8'h00);
		req(0, 8'h8c, 8'h00);
		req(0, 8'h8c, 8'h00);
		repeat (6) @(posedge i_clk);
		#1 chk("ready", 8'h00, {7'h00, o_acc_ready});
		get(st[7:0]);
		get(st[7:0]);
		get(st[7:0]);
		finish_test;
	end
endmodule // tb
